// ==== bench/pdm_cpu_model.sv ====
// Purpose : Behavioural CPU core beside the power-down controller
// Assumes : Bench supplies the request bundle; the return pulse is produced here
// Notes   : Serves each wake interrupt, then returns retDelay+1 CPU clock cycles after the routine starts
`timescale 1ns/1ps

module pdm_cpu_model (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire pdm_pkg::pdm_cpu_t reqIn,
	input  wire pdm_pkg::pdm_ctrl_t ctrl,
	input  wire logic [3:0]        retDelay,
	output pdm_pkg::pdm_cpu_t      cpuReq
);
	logic       busy_q;	// Service routine running
	logic [3:0] cnt_q;	// Cycles left in the routine minus one
	logic       retPulse_q;	// Return pulse

	// ************************************************************
	// Service routine: counts only while the CPU clock runs
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		retPulse_q <= 1'b0;
		if (sys_rst) begin
			busy_q <= 1'b0;
			cnt_q  <= 4'h0;
		end else if (ctrl.wakeIrq) begin
			// Wake interrupt is served first
			busy_q <= 1'b1;
			cnt_q  <= retDelay;
		end else if (busy_q && ctrl.cpuClkEn) begin
			if (cnt_q == 4'h0) begin
				// Return ends the routine
				busy_q     <= 1'b0;
				retPulse_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end

	// Bench fields pass through; only the return pulse is ours
	always_comb begin
		cpuReq           = reqIn;
		cpuReq.intReturn = retPulse_q;
	end
endmodule

// ==== bench/testbench.sv ====
// Purpose : Self-checking bench of the power-down controller
// Assumes : Main oscillator is a crystal, so stop mode is legal
// Notes   : Drivers queue expected wake and fetch events; a monitor checks them
`timescale 1ns/1ps

module testbench;
	typedef struct {
		logic        isWake;	// 1 wake interrupt, 0 reset fetch
		logic [1:0]  cs;	// Expected divider bits
		logic [7:0]  key;	// Expected stop key
		logic        chkPc;	// Compare resume address
		logic [15:0] pc;
		int          t0, lo, hi;	// Launch cycle and allowed delay
	} pdm_note_t;

	logic                sys_clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                pinN    = 1'b1;	// Reset pin, active low
	logic [2:0]          p0Irq   = 3'h0;
	logic [4:0]          p1Irq   = 5'h0;
	logic [7:0]          lineEn  = 8'h00;
	logic [3:0]          retDly  = 4'h0;
	pdm_pkg::pdm_cpu_t   req     = '0;
	pdm_pkg::pdm_cpu_t   cpuReq;
	pdm_pkg::pdm_ctrl_t  ctrl;
	pdm_pkg::pdm_state_t powerState;
	logic [1:0]          clkDivSel_q;
	logic [7:0]          stopKey_q;
	logic [15:0]         resumePc_q, resetVector_q;
	pdm_note_t           notes[$];	// Expected events, oldest first
	pdm_note_t           nt;
	int                  cyc = 0, n_fail = 0, num_checks = 0;
	logic [15:0]         pc;
	logic [1:0]          cs;

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	pdm_power_ctrl pdm_power_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .external_reset_pin_n(pinN),
		.port0_wake_irq_lines(p0Irq), .port1_wake_irq_lines(p1Irq), .wakeLineEn(lineEn), .cpuReq(cpuReq),
		.ctrl(ctrl), .powerState(powerState), .clkDivSel_q(clkDivSel_q), .stopKey_q(stopKey_q),
		.resumePc_q(resumePc_q), .resetVector_q(resetVector_q));
	pdm_cpu_model pdm_cpu_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reqIn(req), .ctrl(ctrl),
		.retDelay(retDly), .cpuReq(cpuReq));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Queue an expected event launched at the current cycle
	task automatic expect_ev(input logic w, input logic [1:0] c, input logic [7:0] k,
		input logic cp, input logic [15:0] p, input int lo, input int hi);
		notes.push_back('{w, c, k, cp, p, cyc, lo, hi});
	endtask

	// Writes all three settings in one cycle
	task automatic wr(input logic [1:0] c, input logic [1:0] s, input logic [7:0] k);
		@(posedge sys_clk);
		req.clkSelWr  <= 1'b1;
		req.clkSelData <= c;
		req.stabSelWr <= 1'b1;
		req.stabSelData <= s;
		req.keyWr     <= 1'b1;
		req.keyData   <= k;
		@(posedge sys_clk);
		req.clkSelWr  <= 1'b0;
		req.stabSelWr <= 1'b0;
		req.keyWr     <= 1'b0;
	endtask

	task automatic op(input logic [7:0] code, input logic [15:0] nxt);
		@(posedge sys_clk);
		req.opValid <= 1'b1;
		req.opcode  <= code;
		req.nextPc  <= nxt;
		@(posedge sys_clk);
		req.opValid <= 1'b0;
	endtask

	// Ends on a settled point a few cycles later
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Bounded wait until back in RUN with every expected event seen
	task automatic wait_run;
		int k;
		for (k = 0; k < 5000 && !(powerState === pdm_pkg::PDM_RUN && notes.size() == 0); k++)
			@(posedge sys_clk);
		if (k == 5000) begin
			n_fail++;
			$display("mismatch t=%0t wait for run timed out", $time);
			close_out();
		end
	endtask

	// ************************************************************
	// Monitor: each wake or fetch pulse takes the oldest note
	// ************************************************************
	always @(posedge sys_clk) begin
		if (!sys_rst && (ctrl.wakeIrq === 1'b1 || ctrl.fetchReset === 1'b1)) begin
			if (notes.size() == 0) begin
				chk(32'h1, 32'h0, "unexpected event");
			end else begin
				nt = notes.pop_front();
				chk(ctrl.wakeIrq, nt.isWake, "event kind");
				chk(clkDivSel_q, nt.cs, "divider bits");
				chk(stopKey_q, nt.key, "stop key");
				if (nt.chkPc) chk(resumePc_q, nt.pc, "resume address");
				chk((cyc - nt.t0 >= nt.lo) && (cyc - nt.t0 <= nt.hi), 1'b1, "wait length");
			end
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		void'($urandom(32'hd49cfd7a));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		expect_ev(1'b0, 2'h0, 8'h00, 1'b0, 16'h0, 256, 275);
		wait_run();
		chk(resetVector_q, 16'h0100, "reset vector");
		// Keyed stop, woken by each line in turn, every interval select
		for (int i = 0; i < 8; i++) begin
			cs = 2'($urandom_range(3, 1));
			pc = 16'($urandom);
			retDly <= 4'($urandom);
			wr(cs, 2'(i % 4), 8'ha5);
			lineEn <= 8'h01 << i;
			req.irqPending <= 1'b1;
			op(8'h7f, pc);
			step(2);
			chk(powerState, pdm_pkg::PDM_STOP, "stop entry");
			chk({ctrl.mainOscEn, ctrl.cpuClkEn, ctrl.periphClkEn}, 3'h0, "clocks off");
			chk({ctrl.regFileHold, ctrl.oscInForceLow}, 2'h3, "holds in stop");
			@(posedge sys_clk);
			{p1Irq, p0Irq} <= {p1Irq, p0Irq} ^ (8'h01 << ((i + 1) % 8));
			step(10);
			chk(powerState, pdm_pkg::PDM_STOP, "disabled line or irq woke");
			// Same-clock inputs move on the edge, never between edges
			@(posedge sys_clk);
			req.irqPending <= 1'b0;
			{p1Irq, p0Irq} <= {p1Irq, p0Irq} ^ (8'h01 << i);
			expect_ev(1'b1, cs, 8'h00, 1'b1, pc, 256 << (i % 4), (256 << (i % 4)) + 12);
			wait_run();
			step(20);
			chk(ctrl.resumeValid, 1'b0, "return clears resume");
		end
		// Stop without key after the wake altered it
		op(8'h7f, 16'($urandom));
		step(4);
		chk({powerState, ctrl.mainOscEn}, {pdm_pkg::PDM_RUN, 1'b1}, "unkeyed stop");
		// Idle, masked then enabled interrupt
		pc = 16'($urandom);
		op(8'h6f, pc);
		step(2);
		chk(powerState, pdm_pkg::PDM_IDLE, "idle entry");
		chk({ctrl.cpuClkEn, ctrl.periphClkEn, ctrl.portDirHold}, 3'h3, "idle clocks");
		@(posedge sys_clk);
		req.irqPending <= 1'b1;
		req.irqGlobalEn <= 1'b0;
		step(20);
		chk(powerState, pdm_pkg::PDM_IDLE, "masked irq woke idle");
		@(posedge sys_clk);
		req.irqGlobalEn <= 1'b1;
		expect_ev(1'b1, cs, 8'h00, 1'b1, pc, 0, 6);
		wait_run();
		@(posedge sys_clk);
		req.irqPending <= 1'b0;
		// Pin reset from stop then from idle; data kept, divider cleared
		for (int j = 0; j < 2; j++) begin
			pc = 16'($urandom);
			wr(2'h3, 2'h0, 8'ha5);
			op(j == 0 ? 8'h7f : 8'h6f, pc);
			step(2);
			@(posedge sys_clk);
			pinN <= 1'b0;
			step(6);
			chk({powerState, ctrl.ctrlRegRst, clkDivSel_q}, {pdm_pkg::PDM_HOLD, 1'b1, 2'h0}, "pin hold");
			@(posedge sys_clk);
			pinN <= 1'b1;
			// Both stop and idle entry left pc as resume address; reset keeps data
			expect_ev(1'b0, 2'h0, 8'h00, 1'b1, pc, 256, 275);
			wait_run();
		end
		close_out();
	end
endmodule

// ==== src/pdm_defs.svh ====
// Purpose : Constants of the power-down mode controller
// Assumes : 50 MHz system clock
// Notes   : Definitions only, no logic
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// ************************************************************
// Opcodes and key values
// ************************************************************
`define PDM_OP_STOP        8'h7f
`define PDM_OP_IDLE        8'h6f
`define PDM_STOP_KEY       8'ha5
`define PDM_KEY_ALTERED    8'h00
`define PDM_KEY_RESET      8'h00

// ************************************************************
// Reset values
// ************************************************************
`define PDM_RESET_VECTOR   16'h0100
`define PDM_CLKDIV_RESET   2'h0
`define PDM_STABSEL_RESET  2'h0

// ************************************************************
// Timing: period and stabilization intervals in ns
// ************************************************************
`define PDM_CLK_NS         20
`define PDM_STAB0_NS       5120
`define PDM_STAB1_NS       10240
`define PDM_STAB2_NS       20480
`define PDM_STAB3_NS       40960
// Least times round up to whole cycles
`define PDM_NS2CYC(ns)     (((ns) + `PDM_CLK_NS - 1) / `PDM_CLK_NS)

`endif

// ==== src/pdm_pkg.sv ====
// Purpose : Types of the power-down mode controller
// Assumes : Constants come from pdm_defs.svh
// Notes   : Nothing here is imported; users write pdm_pkg::name
package pdm_pkg;

	// ************************************************************
	// Power state, one-hot
	// ************************************************************
	typedef enum logic [4:0] {
		PDM_RUN  = 5'h01,	// CPU executing
		PDM_IDLE = 5'h02,	// CPU clock gated, peripherals alive
		PDM_STOP = 5'h04,	// Oscillator frozen
		PDM_STAB = 5'h08,	// Oscillation stabilization wait
		PDM_HOLD = 5'h10 	// External reset held low
	} pdm_state_t;

	// Cause of the wait in progress
	typedef enum logic {
		PDM_BY_RESET = 1'b0,
		PDM_BY_IRQ   = 1'b1
	} pdm_cause_t;

	// ************************************************************
	// CPU side request bundle
	// ************************************************************
	typedef struct packed {
		logic        opValid;	// One-cycle: opcode executed
		logic [7:0]  opcode;	// Executed opcode
		logic [15:0] nextPc;	// Address after that instruction
		logic        intReturn;	// One-cycle: interrupt return executed
		logic        keyWr;		// Write stop_key_register
		logic [7:0]  keyData;
		logic        clkSelWr;	// Write divider bits of clock_select_register
		logic [1:0]  clkSelData;
		logic        stabSelWr;	// Write stabilization interval select
		logic [1:0]  stabSelData;
		logic        irqPending;	// Some enabled interrupt is pending
		logic        irqGlobalEn;	// Interrupts not masked
	} pdm_cpu_t;

	// ************************************************************
	// Control outputs toward clocks, core and ports
	// ************************************************************
	typedef struct packed {
		logic        mainOscEn;	// Main oscillator running
		logic        oscInForceLow;	// Oscillator inputs tied low
		logic        cpuClkEn;	// CPU clock ungated
		logic        periphClkEn;	// Peripheral clocks running
		logic        regFileHold;	// Register file write inhibit
		logic        portDirHold;	// Port directions frozen
		logic        ctrlRegRst;	// Control registers to defaults
		logic        fetchReset;	// One-cycle: fetch from reset vector
		logic        wakeIrq;	// One-cycle: service wake interrupt
		logic        resumeValid;	// Resume address waiting for return
	} pdm_ctrl_t;

endpackage

// ==== src/pdm_power_ctrl.sv ====
// Purpose : Stop and idle power-down control of an 8-bit core
// Assumes : CPU decode reports executed opcodes; pins are asynchronous
// Notes   : Registers are the core's; this block holds the copies it steers
`timescale 1ns/1ps
`include "pdm_defs.svh"

module pdm_power_ctrl #(
	parameter int CNT_W = 12	// Stabilization counter width
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             external_reset_pin_n,
	input  wire logic [2:0]       port0_wake_irq_lines,
	input  wire logic [4:0]       port1_wake_irq_lines,
	input  wire logic [7:0]       wakeLineEn,
	input  wire pdm_pkg::pdm_cpu_t cpuReq,
	output pdm_pkg::pdm_ctrl_t    ctrl,
	output pdm_pkg::pdm_state_t   powerState,
	output logic [1:0]            clkDivSel_q,
	output logic [7:0]            stopKey_q,
	output logic [15:0]           resumePc_q,
	output logic [15:0]           resetVector_q
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		pdm_pkg::pdm_state_t state;		// Power state
		pdm_pkg::pdm_cause_t cause;		// Why the wait runs
		logic                rstS1;		// Reset pin sync stage 1
		logic                rstS2;		// Reset pin sync stage 2
		logic [7:0]          wakeS1;	// Wake lines sync stage 1
		logic [7:0]          wakeS2;	// Wake lines sync stage 2
		logic [7:0]          wakeS3;	// Previous value for edges
		logic [7:0]          key;		// stop_key_register copy
		logic [1:0]          clkDiv;	// Divider select bits
		logic [1:0]          stabSel;	// Programmed interval select
		logic [15:0]         resumePc;	// Address after stop or idle
		logic [15:0]         resetVec;	// Reset fetch address
		pdm_pkg::pdm_ctrl_t  ctrl;		// Registered control outputs
	} pdm_st_t;

	pdm_st_t    st_q;
	pdm_st_t    st_d;
	logic [7:0] wakeEdge;	// Enabled wake line edges
	logic       timerStart;	// Start stabilization wait
	logic [1:0] timerSel;	// Interval for that wait
	logic       timerDone;	// Wait elapsed

	// Stabilization timer, shared by reset and interrupt wake
	pdm_stab_timer #(
		.CNT_W (CNT_W)
	) u_stab (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.start   (timerStart),
		.sel     (timerSel),
		.done    (timerDone)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d                 = st_q;
		st_d.ctrl.fetchReset = 1'b0;
		st_d.ctrl.wakeIrq    = 1'b0;
		st_d.ctrl.ctrlRegRst = 1'b0;
		timerStart           = 1'b0;
		timerSel             = st_q.stabSel;
		// Pins pass two flops before anything looks at them
		st_d.rstS1  = external_reset_pin_n;
		st_d.rstS2  = st_q.rstS1;
		st_d.wakeS1 = {port1_wake_irq_lines, port0_wake_irq_lines};
		st_d.wakeS2 = st_q.wakeS1;
		st_d.wakeS3 = st_q.wakeS2;
		// Either edge of an enabled line; the core's pending logic sets polarity
		wakeEdge = (st_q.wakeS2 ^ st_q.wakeS3) & wakeLineEn;

		// Register writes count only while the CPU executes
		if (st_q.state == pdm_pkg::PDM_RUN) begin
			if (cpuReq.keyWr)
				st_d.key = cpuReq.keyData;
			if (cpuReq.clkSelWr)
				st_d.clkDiv = cpuReq.clkSelData;
			if (cpuReq.stabSelWr)
				st_d.stabSel = cpuReq.stabSelData;
		end

		// Interrupt return consumes the resume address; a new wake below wins
		if (cpuReq.intReturn)
			st_d.ctrl.resumeValid = 1'b0;

		unique case (st_q.state)
			pdm_pkg::PDM_RUN: begin
				if (cpuReq.opValid && cpuReq.opcode == `PDM_OP_STOP) begin
					// Without the key the opcode falls through as a no-op
					if (st_q.key == `PDM_STOP_KEY) begin
						st_d.state    = pdm_pkg::PDM_STOP;
						st_d.resumePc = cpuReq.nextPc;
					end
				end else if (cpuReq.opValid && cpuReq.opcode == `PDM_OP_IDLE) begin
					st_d.state    = pdm_pkg::PDM_IDLE;
					st_d.resumePc = cpuReq.nextPc;
				end
			end
			pdm_pkg::PDM_IDLE: begin
				// Masked interrupts keep the core asleep
				if (cpuReq.irqGlobalEn && cpuReq.irqPending) begin
					st_d.state            = pdm_pkg::PDM_RUN;
					st_d.ctrl.wakeIrq     = 1'b1;
					st_d.ctrl.resumeValid = 1'b1;
				end
			end
			pdm_pkg::PDM_STOP: begin
				// Only the eight pins wake; clock divider stays as set
				if (|wakeEdge) begin
					st_d.state = pdm_pkg::PDM_STAB;
					st_d.cause = pdm_pkg::PDM_BY_IRQ;
					st_d.key   = `PDM_KEY_ALTERED;
					timerStart = 1'b1;
				end
			end
			pdm_pkg::PDM_STAB: begin
				if (timerDone) begin
					st_d.state = pdm_pkg::PDM_RUN;
					if (st_q.cause == pdm_pkg::PDM_BY_RESET) begin
						st_d.ctrl.fetchReset = 1'b1;
					end else begin
						st_d.ctrl.wakeIrq     = 1'b1;
						st_d.ctrl.resumeValid = 1'b1;
					end
				end
			end
			pdm_pkg::PDM_HOLD: begin
				// Pin back high: wait the default interval, then fetch
				if (st_q.rstS2) begin
					st_d.state = pdm_pkg::PDM_STAB;
					st_d.cause = pdm_pkg::PDM_BY_RESET;
					timerStart = 1'b1;
					timerSel   = `PDM_STABSEL_RESET;
				end
			end
		endcase

		// Reset pin low overrides everything but a fetchReset raised above in the same cycle; data registers are not touched
		if (!st_q.rstS2) begin
			st_d.state            = pdm_pkg::PDM_HOLD;
			st_d.ctrl.ctrlRegRst  = 1'b1;
			st_d.clkDiv           = `PDM_CLKDIV_RESET;
			st_d.key              = `PDM_KEY_RESET;
			st_d.stabSel          = `PDM_STABSEL_RESET;
			st_d.ctrl.resumeValid = 1'b0;
			st_d.ctrl.wakeIrq     = 1'b0;
			timerStart            = 1'b0;
		end

		// Clock and hold controls follow the next state
		st_d.ctrl.mainOscEn     = (st_d.state != pdm_pkg::PDM_STOP);
		st_d.ctrl.oscInForceLow = (st_d.state == pdm_pkg::PDM_STOP);
		st_d.ctrl.periphClkEn   = (st_d.state != pdm_pkg::PDM_STOP);
		st_d.ctrl.cpuClkEn      = (st_d.state == pdm_pkg::PDM_RUN);
		st_d.ctrl.regFileHold   = (st_d.state == pdm_pkg::PDM_STOP);
		st_d.ctrl.portDirHold   = (st_d.state == pdm_pkg::PDM_IDLE) ||
		                          (st_d.state == pdm_pkg::PDM_STOP);
	end

	// ************************************************************
	// State register; reset parks in reset hold until the pin is seen high
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_q                  <= '0;
			st_q.state            <= pdm_pkg::PDM_HOLD;
			st_q.resetVec         <= `PDM_RESET_VECTOR;
			st_q.ctrl.mainOscEn   <= 1'b1;
			st_q.ctrl.periphClkEn <= 1'b1;
			st_q.ctrl.ctrlRegRst  <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign ctrl          = st_q.ctrl;
	assign powerState    = st_q.state;
	assign clkDivSel_q   = st_q.clkDiv;
	assign stopKey_q     = st_q.key;
	assign resumePc_q    = st_q.resumePc;
	assign resetVector_q = st_q.resetVec;

	// ************************************************************
	// Checks
	// ************************************************************
	a_stop_entry_keyed: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(st_q.state == pdm_pkg::PDM_RUN && st_q.rstS2 && cpuReq.opValid &&
		 cpuReq.opcode == `PDM_OP_STOP && st_q.key == `PDM_STOP_KEY)
		|=> (!ctrl.mainOscEn && !ctrl.cpuClkEn && !ctrl.periphClkEn && ctrl.regFileHold))
		else $error("keyed stop did not freeze clocks");

	a_stop_no_key: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(st_q.state == pdm_pkg::PDM_RUN && st_q.rstS2 && cpuReq.opValid &&
		 cpuReq.opcode == `PDM_OP_STOP && st_q.key != `PDM_STOP_KEY)
		|=> (powerState == pdm_pkg::PDM_RUN && ctrl.mainOscEn))
		else $error("stop without key was not ignored");

	a_reset_clk_slow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(ctrl.ctrlRegRst) |-> (clkDivSel_q == `PDM_CLKDIV_RESET && stopKey_q == `PDM_KEY_RESET))
		else $error("reset did not clear divider bits");

	a_reset_fetch_vec: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ctrl.fetchReset |-> ($past(st_q.state) == pdm_pkg::PDM_STAB && resetVector_q == `PDM_RESET_VECTOR &&
		                     ctrl.cpuClkEn && $past(timerDone)))
		else $error("reset fetch without finished wait");

	a_wake_lines_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(st_q.state == pdm_pkg::PDM_STOP && st_q.rstS2 && wakeEdge == 8'h00)
		|=> powerState == pdm_pkg::PDM_STOP)
		else $error("stop left without wake line");

	a_wake_keeps_div: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(st_q.state == pdm_pkg::PDM_STOP && st_q.rstS2 && wakeEdge != 8'h00)
		|=> (stopKey_q == `PDM_KEY_ALTERED && clkDivSel_q == $past(clkDivSel_q) && ctrl.mainOscEn))
		else $error("interrupt wake changed divider or kept key");

	a_wake_resume: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ctrl.wakeIrq |-> (ctrl.resumeValid && ctrl.cpuClkEn && resumePc_q == $past(resumePc_q)))
		else $error("wake interrupt without resume address");

	a_idle_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(st_q.state == pdm_pkg::PDM_IDLE && st_q.rstS2 && !cpuReq.irqGlobalEn)
		|=> (powerState == pdm_pkg::PDM_IDLE && !ctrl.cpuClkEn && ctrl.periphClkEn && ctrl.portDirHold))
		else $error("idle left while interrupts masked");

	a_idle_irq_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(st_q.state == pdm_pkg::PDM_IDLE && st_q.rstS2 && cpuReq.irqGlobalEn && cpuReq.irqPending)
		|=> (ctrl.wakeIrq && clkDivSel_q == $past(clkDivSel_q)) ##1 !ctrl.wakeIrq)
		else $error("enabled interrupt did not end idle");

endmodule

// ==== src/pdm_stab_timer.sv ====
// Purpose : Oscillation stabilization interval timer
// Assumes : Start only while not busy
// Notes   : Done is a one-cycle pulse from a flop
`timescale 1ns/1ps
`include "pdm_defs.svh"

module pdm_stab_timer #(
	parameter int CNT_W = 12	// Counter width
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       start,
	input  wire logic [1:0] sel,
	output logic            done
);

	// Cycle counts derived from the interval times
	localparam int CYC0 = `PDM_NS2CYC(`PDM_STAB0_NS);
	localparam int CYC1 = `PDM_NS2CYC(`PDM_STAB1_NS);
	localparam int CYC2 = `PDM_NS2CYC(`PDM_STAB2_NS);
	localparam int CYC3 = `PDM_NS2CYC(`PDM_STAB3_NS);

	// Refuse a counter too narrow for the longest interval
	if (CYC3 > (1 << CNT_W))
		$error("pdm_stab_timer: CNT_W too small");

	typedef struct packed {
		logic             busy;	// Counting
		logic [CNT_W-1:0] cnt;	// Cycles left minus one
		logic             done;	// End pulse
	} pdm_tmr_t;

	pdm_tmr_t st_q;
	pdm_tmr_t st_d;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (start) begin
			st_d.busy = 1'b1;
			unique case (sel)
				2'h0: st_d.cnt = CNT_W'(CYC0 - 1);
				2'h1: st_d.cnt = CNT_W'(CYC1 - 1);
				2'h2: st_d.cnt = CNT_W'(CYC2 - 1);
				2'h3: st_d.cnt = CNT_W'(CYC3 - 1);
			endcase
		end else if (st_q.busy) begin
			// Last cycle of the interval
			if (st_q.cnt == '0) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign done = st_q.done;

endmodule
